//--- verilog/input_capture_unit.sv
// Input capture unit: edge timestamping into a FIFO, APB registers, interrupt
`timescale 1ns/100ps

// Overview of operation
// - Idle-stop bit halts capture during CPU idle; mode 111 wake still works
// - Timebase bit picks timer two, else three
// - Captures-per-interrupt field sets interrupt frequency
// - Read-only overflow flag, hardware-set and cleared
// - Read-only buffer not-empty bit tracks FIFO
// - Mode 111: rising-edge wake interrupt in sleep/idle
// - Modes 000 and 110 disable the channel
// - Modes 101/100 capture every 16th/4th rise
// - Modes 011/010 capture rising/falling edges
// - Mode 001 captures both edges, interrupt each
// - Unimplemented control bits read zero, reset zero
// - Five-bit pin number selects the input pin
module input_capture_unit
  import capture_pkg::*;
#(
  parameter int PIN_COUNT = 26,
  parameter int FIFO_DEPTH = 4,
  parameter int TIMER_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PIN_COUNT-1:0] remappable_pin,
  input wire logic [TIMER_W-1:0] timer_two_count,
  input wire logic [TIMER_W-1:0] timer_three_count,
  output logic irq
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

  // =====================================================================
  // Registers
  control_s ctrl;
  logic [PIN_SEL_W-1:0] pin_select;
  logic [EV_COUNT-1:0] status;
  logic [EV_COUNT-1:0] mask;
  logic cpu_idle;
  logic cpu_sleep;
  logic overrun;
  logic [TIMER_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] fill;
  logic [3:0] prescale;
  logic [1:0] cpi_count;
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic in_prev;
  logic in_now;

  // APB decode: zero-wait slave, every access completes in its access phase
  logic wr_en;
  logic rd_en;
  logic buf_read;
  logic pop_armed;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign buf_read = rd_en & pop_armed & (paddr == ADDR_BUFFER);

  // Pop only what the setup cycle returned: a capture that lands at the setup
  // edge of a read from an empty buffer would otherwise be popped unseen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pop_armed <= 1'b0;
    end else begin
      pop_armed <= psel & ~penable & ~pwrite & (paddr == ADDR_BUFFER) & (fill != '0);
    end
  end

  // =====================================================================
  // Pin synchroniser: two flops on every remappable pin before the mux
  // Synchronising all pins, not just the chosen one, keeps remapping clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= remappable_pin;
      pin_sync <= pin_meta;
    end
  end

  // Selected pin; out-of-range numbers read as low
  // Remapping while a capture mode runs can show one false edge
  always_comb begin
    in_now = 1'b0;
    if (32'(pin_select) < PIN_COUNT) begin
      in_now = pin_sync[pin_select];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_prev <= 1'b0;
    end else begin
      in_prev <= in_now;
    end
  end

  // Edge pulses last one cycle; in_prev resets low to match an idle pin
  edges_s edge_seen;
  assign edge_seen.rise = in_now & ~in_prev;
  assign edge_seen.fall = ~in_now & in_prev;

  // =====================================================================
  // Event qualification
  logic halted;
  logic capture_ev;
  logic wake_ev;
  logic prescale_hit;
  logic [3:0] prescale_last;

  // Halting in idle freezes capture only; the wake mode is meant for idle
  // Capture and prescaler freeze together; the FIFO stays readable
  assign halted = ctrl.idle_stop_select & cpu_idle;
  assign prescale_last = (ctrl.capture_mode_select == MODE_RISE_16) ?
                         PRESCALE_16_LAST : PRESCALE_4_LAST;
  assign prescale_hit = edge_seen.rise & (prescale == prescale_last);

  always_comb begin
    capture_ev = 1'b0;
    wake_ev = 1'b0;
    case (ctrl.capture_mode_select)
      MODE_EVERY_EDGE: capture_ev = edge_seen.rise | edge_seen.fall;
      MODE_FALLING: capture_ev = edge_seen.fall;
      MODE_RISING: capture_ev = edge_seen.rise;
      MODE_RISE_4, MODE_RISE_16: capture_ev = prescale_hit;
      MODE_WAKE: wake_ev = edge_seen.rise & (cpu_sleep | cpu_idle);
      MODE_OFF, MODE_UNUSED: capture_ev = 1'b0;
      default: capture_ev = 1'b0;
    endcase
    if (halted) begin
      capture_ev = 1'b0;
    end
  end

  // Prescaler counts rising edges; restarts whenever the mode is not prescaled
  // Edges seen while halted are not counted, so a halt pauses the division
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
    end else if (ctrl.capture_mode_select != MODE_RISE_4 &&
                 ctrl.capture_mode_select != MODE_RISE_16) begin
      prescale <= '0;
    end else if (edge_seen.rise && !halted) begin
      prescale <= prescale_hit ? 4'h0 : prescale + 4'h1;
    end
  end

  // =====================================================================
  // Capture FIFO
  logic push;
  logic full;
  logic [TIMER_W-1:0] stamp;
  assign full = (32'(fill) == FIFO_DEPTH);
  assign push = capture_ev & ~full;
  assign stamp = ctrl.timebase_select ? timer_two_count : timer_three_count;

  // Storage has no reset: only entries below the fill count are ever read
  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_mem[wr_ptr] <= stamp;
    end
  end

  // Pointers wrap at the depth so non-power-of-two depths work too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (32'(wr_ptr) == FIFO_DEPTH - 1) ? '0 : wr_ptr + 1'b1;
      end
      if (buf_read) begin
        rd_ptr <= (32'(rd_ptr) == FIFO_DEPTH - 1) ? '0 : rd_ptr + 1'b1;
      end
      fill <= fill + CNT_W'(push) - CNT_W'(buf_read);
    end
  end

  // Overflow: set on a drop, cleared by hardware once the FIFO is drained.
  // A drop in the draining cycle keeps the flag set.
  // Reading the flag does not clear it; only draining the buffer does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (capture_ev && full) begin
      overrun <= 1'b1;
    end else if (buf_read && fill == CNT_W'(1)) begin
      overrun <= 1'b0;
    end
  end

  // =====================================================================
  // Captures-per-interrupt counter
  // Cleared only when the channel is turned off, so a mode change keeps a
  // partial count; software writes mode 000 first for a clean start
  logic cpi_hit;
  assign cpi_hit = capture_ev &
                   ((ctrl.capture_mode_select == MODE_EVERY_EDGE) ||
                    (cpi_count == ctrl.captures_per_interrupt));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpi_count <= '0;
    end else if (ctrl.capture_mode_select == MODE_OFF) begin
      cpi_count <= '0;
    end else if (capture_ev) begin
      cpi_count <= cpi_hit ? 2'h0 : cpi_count + 2'h1;
    end
  end

  // =====================================================================
  // Control, pin map, mask and power-state registers
  // Only writable fields are stored; the two flags are derived from the FIFO
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else if (wr_en && paddr == ADDR_CONTROL) begin
      ctrl.idle_stop_select <= pwdata[IDLE_STOP_BIT];
      ctrl.timebase_select <= pwdata[TIMEBASE_BIT];
      ctrl.captures_per_interrupt <= pwdata[CPI_HI:CPI_LO];
      ctrl.capture_mode_select <= mode_e'(pwdata[MODE_HI:MODE_LO]);
    end
  end

  // Pin number of the remappable input feeding the channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_select <= '0;
    end else if (wr_en && paddr == ADDR_PIN_MAP) begin
      pin_select <= pwdata[PIN_SEL_W-1:0];
    end
  end

  // Interrupt mask, same layout as the status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
    end else if (wr_en && paddr == ADDR_MASK) begin
      mask <= pwdata[EV_COUNT-1:0];
    end
  end

  // CPU state seen by the channel; software models idle and sleep here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_idle <= 1'b0;
      cpu_sleep <= 1'b0;
    end else if (wr_en && paddr == ADDR_POWER) begin
      cpu_idle <= pwdata[POWER_IDLE_BIT];
      cpu_sleep <= pwdata[POWER_SLEEP_BIT];
    end
  end

  // Sticky status: write one to clear, a new event wins over the clear
  logic [EV_COUNT-1:0] ev_set;
  logic [EV_COUNT-1:0] ev_clr;
  assign ev_set = {wake_ev, capture_ev & full, cpi_hit};
  assign ev_clr = (wr_en && paddr == ADDR_STATUS) ? pwdata[EV_COUNT-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= (status & ~ev_clr) | ev_set;
    end
  end

  // Interrupt follows the next status value, so it rises with its status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~ev_clr) | ev_set) & mask);
    end
  end

  // =====================================================================
  // APB read path; read data registered in the setup cycle
  logic [31:0] next_prdata;
  logic [15:0] ctrl_view;
  logic mapped;

  // Control view: stored fields, hardware flags, zeros in unimplemented bits
  always_comb begin
    ctrl_view = CONTROL_RESET;
    ctrl_view[IDLE_STOP_BIT] = ctrl.idle_stop_select;
    ctrl_view[TIMEBASE_BIT] = ctrl.timebase_select;
    ctrl_view[CPI_HI:CPI_LO] = ctrl.captures_per_interrupt;
    ctrl_view[OVERRUN_BIT] = overrun;
    ctrl_view[NOT_EMPTY_BIT] = (fill != '0);
    ctrl_view[MODE_HI:MODE_LO] = ctrl.capture_mode_select;
  end

  // Read mux; unmapped or unaligned addresses answer zero with an error
  always_comb begin
    next_prdata = '0;
    mapped = 1'b1;
    case (paddr)
      ADDR_CONTROL: next_prdata = {16'h0000, ctrl_view};
      ADDR_BUFFER: next_prdata = (fill != '0) ? 32'(fifo_mem[rd_ptr]) : '0;
      ADDR_PIN_MAP: next_prdata = 32'(pin_select);
      ADDR_STATUS: next_prdata = 32'(status);
      ADDR_MASK: next_prdata = 32'(mask);
      ADDR_POWER: next_prdata = 32'({cpu_sleep, cpu_idle});
      default: mapped = 1'b0;
    endcase
  end

  // Setup cycle loads read data and error; the access phase then completes
  // Write transfers return zero data; pready stands for one cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= ~mapped;
      pready <= 1'b1;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : input_capture_unit

//--- verilog/capture_pkg.sv
// Package: register map, field layout and types for the input capture unit
package capture_pkg;
  // =====================================================================
  // Register offsets (byte addresses on APB)
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_BUFFER = 12'h004;
  localparam logic [11:0] ADDR_PIN_MAP = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_MASK = 12'h010;
  localparam logic [11:0] ADDR_POWER = 12'h014;

  // =====================================================================
  // Control register field positions
  localparam int IDLE_STOP_BIT = 13;
  localparam int TIMEBASE_BIT = 7;
  localparam int CPI_HI = 6;
  localparam int CPI_LO = 5;
  localparam int OVERRUN_BIT = 4;
  localparam int NOT_EMPTY_BIT = 3;
  localparam int MODE_HI = 2;
  localparam int MODE_LO = 0;
  localparam logic [15:0] CONTROL_WRITE_MASK = 16'h20E7;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;

  // Status/mask bit positions
  localparam int EV_CAPTURE = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_COUNT = 3;

  // Power state bits
  localparam int POWER_IDLE_BIT = 0;
  localparam int POWER_SLEEP_BIT = 1;

  // Counter constants
  localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
  localparam int PIN_SEL_W = 5;

  // =====================================================================
  // Capture modes
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_EVERY_EDGE = 3'h1,
    MODE_FALLING = 3'h2,
    MODE_RISING = 3'h3,
    MODE_RISE_4 = 3'h4,
    MODE_RISE_16 = 3'h5,
    MODE_UNUSED = 3'h6,
    MODE_WAKE = 3'h7
  } mode_e;

  // Control fields as carried inside the block
  typedef struct packed {
    logic idle_stop_select;
    logic timebase_select;
    logic [1:0] captures_per_interrupt;
    mode_e capture_mode_select;
  } control_s;

  // Edge detector outputs
  typedef struct packed {
    logic rise;
    logic fall;
  } edges_s;
endpackage : capture_pkg

//--- bench/input_capture_unit_assertions.sv
// Checker: bus timing, read-back layout and interrupt behaviour at the ports
`timescale 1ns/100ps
module capture_checker
  import capture_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  logic rd_acc;
  // Completed write and read phases seen on the bus
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = pready && !pwrite;
  // ===================================================================
  // Properties
  answer_timing_a: assert property (psel && !penable |=> pready && penable)
    else $error("access phase without ready");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  bus_error_a: assert property (pready |-> pslverr == (paddr > ADDR_POWER || paddr[1:0] != 2'h0))
    else $error("error response on wrong address");
  error_data_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read returned data");
  control_layout_a: assert property (
    rd_acc && paddr == ADDR_CONTROL |-> prdata[31:14] == 18'h0 && prdata[12:8] == 5'h0)
    else $error("unimplemented control bits set");
  pin_width_a: assert property (rd_acc && paddr == ADDR_PIN_MAP |-> prdata[31:5] == 27'h0)
    else $error("pin number wider than five bits");
  status_width_a: assert property (rd_acc && paddr == ADDR_STATUS |-> prdata[31:3] == 29'h0)
    else $error("status bits beyond event set");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("interrupt dropped without a write");
  // Main scenarios reached
  cover property (pslverr);
  cover property ($rose(irq));
  cover property (rd_acc && paddr == ADDR_BUFFER && prdata != 32'h0);
endmodule : capture_checker

bind input_capture_unit capture_checker i_capture_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));

//--- bench/pin_source.sv
// Partner model: external signal on the chosen remappable pin, noise elsewhere
`timescale 1ns/100ps
module pin_source #(
  parameter int PIN_COUNT = 26
) (
  input wire logic pclk,
  input wire logic [4:0] pin_sel,
  input wire logic level,
  output logic [PIN_COUNT-1:0] pins
);
  logic [PIN_COUNT-1:0] noise = '0;
  // Other pins toggle every cycle, so a wrong pick shows as stray edges
  always @(posedge pclk) noise <= ~noise;
  always_comb begin
    pins = noise;
    pins[pin_sel] = level;
  end
endmodule : pin_source

//--- bench/tb_input_capture_unit.sv
// Testbench: register, capture, overflow and interrupt checks over APB
`timescale 1ns/100ps
module tb_input_capture_unit
  import capture_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, level, err, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] t2, t3;
  logic [25:0] pins;
  int n_mismatch = 0;
  int checks_done = 0;
  int m, c, i;
  int np[7] = '{2, 1, 2, 2, 4, 16, 2};
  int nc[7] = '{0, 2, 2, 2, 1, 1, 0};
  input_capture_unit i_input_capture_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .remappable_pin(pins), .timer_two_count(t2),
    .timer_three_count(t3), .irq(irq));
  pin_source i_pin_source (.pclk(pclk), .pin_sel(5'h07), .level(level), .pins(pins));
  // ===================================================================
  // Clock and bus tasks
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // One APB transfer; only the watchdog ends a wait for ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Input pulses, each long enough for the synchroniser to see both edges
  task automatic pulse(input int n);
    repeat (n) begin
      level <= 1'b1;
      repeat (8) @(posedge pclk);
      level <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask : pulse
  // Reads the buffer until empty, checking order and count
  task automatic drain(input int n, input logic [15:0] v, input logic [15:0] s);
    int k;
    k = 0;
    rd(ADDR_CONTROL);
    while (q[NOT_EMPTY_BIT] === 1'b1 && k < 8) begin
      rd(ADDR_BUFFER);
      chk(q, {16'h0, v});
      v = v + s;
      k++;
      rd(ADDR_CONTROL);
    end
    chk(k, n);
  endtask : drain
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  // Watchdog: the sequence needs well under a tenth of this
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end
  // ===================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, level, presetn} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    t2 = 16'h2A00;
    t3 = 16'h3B00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CONTROL);
    chk(q, 32'h0);
    wr(ADDR_CONTROL, 32'hFFFF_FFF8);
    rd(ADDR_CONTROL);
    chk(q, 32'h20E0);
    wr(ADDR_PIN_MAP, 32'h7);
    rd(ADDR_PIN_MAP);
    chk(q, 32'h7);
    wr(12'hFFC, 32'h1);
    chk(err, 1'b1);
    // Modes 000 to 110, timer choice alternating with the low mode bit
    for (m = 0; m < 7; m++) begin
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_CONTROL, {24'h0, m[0], 4'h0, m[2:0]});
      pulse(np[m]);
      drain(nc[m], m[0] ? t2 : t3, 16'h0);
      wr(ADDR_STATUS, 32'h7);
    end
    // Five captures into four places: last one dropped, order kept
    wr(ADDR_CONTROL, 32'h3);
    for (i = 0; i < 5; i++) begin
      t3 <= 16'h3B00 + 16'(i);
      pulse(1);
    end
    rd(ADDR_CONTROL);
    chk(q[OVERRUN_BIT], 1'b1);
    drain(4, 16'h3B00, 16'h1);
    rd(ADDR_STATUS);
    chk(q, 32'h3);
    wr(ADDR_STATUS, 32'h7);
    t3 <= 16'h3B00;
    // Captures per interrupt, all four settings
    wr(ADDR_MASK, 32'h1);
    for (c = 0; c < 4; c++) begin
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_CONTROL, {25'h0, c[1:0], 5'h03});
      pulse(c);
      chk(irq, 1'b0);
      pulse(1);
      chk(irq, 1'b1);
      wr(ADDR_STATUS, 32'h1);
      drain(c + 1, t3, 16'h0);
      chk(irq, 1'b0);
    end
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_CONTROL, 32'hE1);
    level <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(irq, 1'b1);
    level <= 1'b0;
    repeat (8) @(posedge pclk);
    wr(ADDR_STATUS, 32'h7);
    drain(2, t2, 16'h0);
    // Masked event: status set, line stays low
    wr(ADDR_MASK, 32'h0);
    wr(ADDR_STATUS, 32'h7);
    pulse(1);
    chk(irq, 1'b0);
    rd(ADDR_STATUS);
    chk(q, 32'h1);
    drain(2, t2, 16'h0);
    // Idle stop honoured, then cleared while still idle
    wr(ADDR_POWER, 32'h1);
    wr(ADDR_CONTROL, 32'h2003);
    pulse(1);
    drain(0, t3, 16'h0);
    wr(ADDR_CONTROL, 32'h0003);
    pulse(1);
    drain(1, t3, 16'h0);
    // Wake edge ignored while awake, counted while asleep
    wr(ADDR_POWER, 32'h0);
    wr(ADDR_STATUS, 32'h7);
    wr(ADDR_MASK, 32'h4);
    wr(ADDR_CONTROL, 32'h7);
    pulse(1);
    rd(ADDR_STATUS);
    chk(q, 32'h0);
    wr(ADDR_POWER, 32'h2);
    pulse(1);
    chk(irq, 1'b1);
    rd(ADDR_STATUS);
    chk(q, 32'h4);
    drain(0, t3, 16'h0);
    wrap_up;
  end
endmodule : tb_input_capture_unit
